// ==== rtl/wdog_pkg.sv ====
// Constants, register map and field layout of the watchdog block
// Assumes one oscillator clock and byte addressing on an APB register port
package wdog_pkg;

  // ****************************************************************
  // Register map (indexes, byte address is four times the index)
  // ****************************************************************
  localparam int ADDR_W = 18;
  localparam logic [15:0] CLEAR_PORT_INDEX = 16'hffff;
  localparam logic [15:0] OPTIONS_INDEX = 16'h001f;
  localparam logic [15:0] CAUSE_INDEX = 16'h0020;
  localparam logic [15:0] BREAK_AUX_INDEX = 16'h0021;
  localparam logic [15:0] STATUS_INDEX = 16'h0022;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int OPT_DISABLE_BIT = 0;
  localparam int OPT_STOP_ENABLE_BIT = 1;
  localparam int OPT_SHORT_RECOVERY_BIT = 2;
  localparam int OPT_TRIP_SELECT_BIT = 3;
  localparam int OPT_PIN_ENABLE_BIT = 4;
  localparam int OPT_PERIOD_SELECT_BIT = 7;
  localparam logic [7:0] OPTIONS_RESET = 8'h00;
  localparam logic [7:0] OPTIONS_WRITABLE = 8'h9f;
  localparam int CAUSE_WATCHDOG_BIT = 0;
  localparam int BREAK_DISABLE_BIT = 0;
  localparam logic [7:0] RESET_VECTOR_LOW = 8'h00;

  // ****************************************************************
  // Cycle counts
  // ****************************************************************
  localparam int PRESCALE_BITS = 12;
  localparam int WATCHDOG_BITS = 6;
  localparam int CLEAR_LOW_STAGE = 4;
  localparam int LONG_PERIOD = 262128;
  localparam int SHORT_PERIOD = 8176;
  localparam int SHORT_SPAN_BITS = 13;
  localparam int PIN_PULSE_CYCLES = 32;
  localparam int SHORT_RECOVERY_CYCLES = 32;
  localparam int LONG_RECOVERY_CYCLES = 4096;
  localparam int POR_DELAY_CYCLES = 4096;
  localparam int TIMER_W = 13;

  // ****************************************************************
  // Stop mode sequencing
  // ****************************************************************
  typedef enum logic [2:0]
  {
    ST_RUN = 3'b001,
    ST_STOPPED = 3'b010,
    ST_RECOVER = 3'b100
  } stop_state_t;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [15:0] index);
    reg_hit = (addr == {index, 2'b00});
  endfunction : reg_hit

endpackage : wdog_pkg

// ==== rtl/cycle_timer.sv ====
// One-shot timer that stays busy for a loaded number of cycles
// Assumes a synchronous active-high reset and a clock enable
`timescale 1ns/100ps
`default_nettype none
module cycle_timer #(
  parameter int WIDTH = 13
) (
  input wire logic sys_clk_in,             // Oscillator clock
  input wire logic reset_in,               // Synchronous reset
  input wire logic ce_in,                  // Clock enable
  input wire logic start_in,               // Load length and start
  input wire logic [WIDTH-1:0] length_in,  // Busy cycles
  output logic busy_out,                   // High while running
  output logic done_out                    // Pulse after last cycle
);

  logic [WIDTH-1:0] remaining;

  initial
  begin
    if (WIDTH < 2)
    begin
      $error("cycle_timer width too small");
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      remaining <= '0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end
    else if (ce_in)
    begin
      done_out <= 1'b0;
      if (start_in)
      begin
        remaining <= length_in - WIDTH'(1);
        busy_out <= 1'b1;
      end
      else if (busy_out)
      begin
        remaining <= remaining - WIDTH'(1);
        if (remaining == '0)
        begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
        end
      end
    end
  end

endmodule : cycle_timer
`default_nettype wire

// ==== rtl/watchdog_with_config_options.sv ====
// Watchdog with its write-once options register behind an APB slave
// Assumes APB requests synchronous to the oscillator clock, reset_in is power-on
//
// Design decision made here: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module watchdog_with_config_options #(
  parameter int PRESCALE_WIDTH = wdog_pkg::PRESCALE_BITS,
  parameter int WATCHDOG_WIDTH = wdog_pkg::WATCHDOG_BITS
) (
  input wire logic sys_clk_in,                              // Oscillator clock
  input wire logic reset_in,                                // Power-on reset
  input wire logic ce_in,                                   // Clock enable
  input wire logic psel_in,                                 // APB select
  input wire logic penable_in,                              // APB enable
  input wire logic pwrite_in,                               // APB write
  input wire logic [wdog_pkg::ADDR_W-1:0] paddr_in,         // APB byte address
  input wire logic [31:0] pwdata_in,                        // APB write data
  input wire logic [3:0] pstrb_in,                          // APB byte strobes
  output logic [31:0] prdata_out,                           // APB read data
  output logic pready_out,                                  // APB ready
  output logic pslverr_out,                                 // APB error
  input wire logic monitor_mode_in,                         // Monitor mode
  input wire logic high_test_voltage_in,                    // Test voltage on irq pin
  input wire logic break_active_in,                         // Break interrupt running
  input wire logic stop_instr_in,                           // Stop instruction pulse
  input wire logic wake_in,                                 // Stop wake-up pulse
  input wire logic lvi_reset_in,                            // Low-voltage reset pulse
  input wire logic internal_reset_in,                       // Other internal reset pulse
  output logic reset_pin_out,                               // Reset pin level driven
  output logic reset_pin_oe_out,                            // Reset pin drive enable
  output logic system_reset_out,                            // Watchdog reset request
  output logic illegal_opcode_out,                          // Stop refused
  output logic stopped_out,                                 // Stop or recovery
  output logic recovery_done_out,                           // Stop recovery ended
  output logic por_done_out,                                // Power-up delay over
  output logic low_voltage_trip_select_out                  // Trip select option
);

  localparam int CHAIN_W = PRESCALE_WIDTH + WATCHDOG_WIDTH;
  localparam int TW = wdog_pkg::TIMER_W;

  initial
  begin
    if (PRESCALE_WIDTH < wdog_pkg::PRESCALE_BITS || WATCHDOG_WIDTH < 1 || CHAIN_W < 18 || CHAIN_W > 29)
    begin
      $error("watchdog chain width unsupported by period match or status word");
    end
  end

  // ****************************************************************
  // Counter chain and option state
  // ****************************************************************
  logic [CHAIN_W-1:0] chain;
  logic [7:0] options;
  logic options_locked;
  logic cause_watchdog;
  logic break_disable;
  logic internal_reset;
  logic timeout_match;
  logic watchdog_active;
  logic fire;
  wdog_pkg::stop_state_t stop_state;
  logic [TW-1:0] recovery_length;
  logic recovery_start;
  logic recovery_busy;
  logic recovery_done;
  logic por_start;
  logic por_busy;
  logic por_done;
  logic pin_start;
  logic pin_busy;

  // APB access decode
  logic setup_phase;
  logic write_edge;
  logic hit_clear;
  logic hit_options;
  logic hit_cause;
  logic hit_break;
  logic hit_status;
  logic hit_any;
  logic [31:0] next_prdata;

  assign setup_phase = psel_in && !penable_in;
  assign write_edge = psel_in && penable_in && pready_out && pwrite_in && pstrb_in[0];
  assign hit_clear = wdog_pkg::reg_hit(paddr_in, wdog_pkg::CLEAR_PORT_INDEX);
  assign hit_options = wdog_pkg::reg_hit(paddr_in, wdog_pkg::OPTIONS_INDEX);
  assign hit_cause = wdog_pkg::reg_hit(paddr_in, wdog_pkg::CAUSE_INDEX);
  assign hit_break = wdog_pkg::reg_hit(paddr_in, wdog_pkg::BREAK_AUX_INDEX);
  assign hit_status = wdog_pkg::reg_hit(paddr_in, wdog_pkg::STATUS_INDEX);
  assign hit_any = hit_clear || hit_options || hit_cause || hit_break || hit_status;

  // ****************************************************************
  // Timeout detection
  // ****************************************************************
  always_comb
  begin
    if (options[wdog_pkg::OPT_PERIOD_SELECT_BIT])
    begin
      timeout_match = (chain[wdog_pkg::SHORT_SPAN_BITS-1:0]
                       == wdog_pkg::SHORT_SPAN_BITS'(wdog_pkg::SHORT_PERIOD));
    end
    else
    begin
      timeout_match = (chain == CHAIN_W'(wdog_pkg::LONG_PERIOD));
    end
  end

  assign watchdog_active = !options[wdog_pkg::OPT_DISABLE_BIT]
                           && !(monitor_mode_in && high_test_voltage_in)
                           && !(monitor_mode_in && break_active_in && break_disable);
  assign fire = timeout_match && watchdog_active && (stop_state != wdog_pkg::ST_STOPPED)
                && !internal_reset;

  // Internal reset one cycle after any source
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      internal_reset <= 1'b0;
      system_reset_out <= 1'b0;
    end
    else if (ce_in)
    begin
      internal_reset <= fire || lvi_reset_in || internal_reset_in;
      system_reset_out <= fire;
    end
  end

  // Chain counts in run and recovery alike
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      chain <= '0;
    end
    else if (ce_in)
    begin
      if (internal_reset)
      begin
        chain <= '0;
      end
      else if ((stop_instr_in && options[wdog_pkg::OPT_STOP_ENABLE_BIT] && stop_state == wdog_pkg::ST_RUN)
               || por_done)
      begin
        chain[PRESCALE_WIDTH-1:0] <= '0;
        chain[CHAIN_W-1:PRESCALE_WIDTH] <= chain[CHAIN_W-1:PRESCALE_WIDTH];
      end
      else if (write_edge && hit_clear)
      begin
        chain[CHAIN_W-1:wdog_pkg::CLEAR_LOW_STAGE] <= '0;
        chain[wdog_pkg::CLEAR_LOW_STAGE-1:0] <= chain[wdog_pkg::CLEAR_LOW_STAGE-1:0]
                                                + wdog_pkg::CLEAR_LOW_STAGE'(1);
      end
      else if (stop_state != wdog_pkg::ST_STOPPED)
      begin
        chain <= chain + CHAIN_W'(1);
      end
    end
  end

  // ****************************************************************
  // Stop mode and recovery
  // ****************************************************************
  always_comb
  begin
    if (lvi_reset_in || !options[wdog_pkg::OPT_SHORT_RECOVERY_BIT])
    begin
      recovery_length = TW'(wdog_pkg::LONG_RECOVERY_CYCLES);
    end
    else
    begin
      recovery_length = TW'(wdog_pkg::SHORT_RECOVERY_CYCLES);
    end
  end

  assign recovery_start = (stop_state == wdog_pkg::ST_STOPPED)
                          && (wake_in || lvi_reset_in || internal_reset_in);

  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      stop_state <= wdog_pkg::ST_RUN;
      stopped_out <= 1'b0;
      illegal_opcode_out <= 1'b0;
      recovery_done_out <= 1'b0;
    end
    else if (ce_in)
    begin
      illegal_opcode_out <= 1'b0;
      recovery_done_out <= recovery_done;
      case (stop_state)
        wdog_pkg::ST_RUN:
        begin
          if (stop_instr_in && !internal_reset)
          begin
            if (options[wdog_pkg::OPT_STOP_ENABLE_BIT])
            begin
              stop_state <= wdog_pkg::ST_STOPPED;
              stopped_out <= 1'b1;
            end
            else
            begin
              illegal_opcode_out <= 1'b1;
            end
          end
        end
        wdog_pkg::ST_STOPPED:
        begin
          if (recovery_start)
          begin
            stop_state <= wdog_pkg::ST_RECOVER;
          end
        end
        wdog_pkg::ST_RECOVER:
        begin
          if (recovery_done)
          begin
            stop_state <= wdog_pkg::ST_RUN;
            stopped_out <= 1'b0;
          end
        end
        default:
        begin
          stop_state <= wdog_pkg::ST_RUN;
          stopped_out <= 1'b0;
        end
      endcase
    end
  end

  cycle_timer #(.WIDTH(TW)) recovery_timer (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .start_in(recovery_start),
    .length_in(recovery_length),
    .busy_out(recovery_busy),
    .done_out(recovery_done)
  );

  // ****************************************************************
  // Power-up delay and reset pin pulse
  // ****************************************************************
  logic por_armed;

  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      por_armed <= 1'b1;
      por_done_out <= 1'b0;
      reset_pin_out <= 1'b0;
    end
    else if (ce_in)
    begin
      por_armed <= 1'b0;
      reset_pin_out <= 1'b0;
      if (por_done)
      begin
        por_done_out <= 1'b1;
      end
    end
  end

  assign por_start = por_armed;
  assign pin_start = fire && options[wdog_pkg::OPT_PIN_ENABLE_BIT];

  cycle_timer #(.WIDTH(TW)) por_timer (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .start_in(por_start),
    .length_in(TW'(wdog_pkg::POR_DELAY_CYCLES)),
    .busy_out(por_busy),
    .done_out(por_done)
  );

  cycle_timer #(.WIDTH(TW)) pin_timer (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .start_in(pin_start),
    .length_in(TW'(wdog_pkg::PIN_PULSE_CYCLES)),
    .busy_out(pin_busy),
    .done_out()
  );

  assign reset_pin_oe_out = pin_busy;

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Options: power-on keeps pin enable and trip select across other resets
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      options <= wdog_pkg::OPTIONS_RESET;
      options_locked <= 1'b0;
    end
    else if (ce_in)
    begin
      if (internal_reset)
      begin
        options[wdog_pkg::OPT_TRIP_SELECT_BIT - 1:0] <= wdog_pkg::OPTIONS_RESET[wdog_pkg::OPT_TRIP_SELECT_BIT - 1:0];
        options[7:wdog_pkg::OPT_PIN_ENABLE_BIT + 1] <= wdog_pkg::OPTIONS_RESET[7:wdog_pkg::OPT_PIN_ENABLE_BIT + 1];
        options_locked <= 1'b0;
      end
      else if (write_edge && hit_options && !options_locked)
      begin
        options <= pwdata_in[7:0] & wdog_pkg::OPTIONS_WRITABLE;
        options_locked <= 1'b1;
      end
    end
  end

  assign low_voltage_trip_select_out = options[wdog_pkg::OPT_TRIP_SELECT_BIT];

  // Cause flag: set wins over a write-one clear
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      cause_watchdog <= 1'b0;
      break_disable <= 1'b0;
    end
    else if (ce_in)
    begin
      if (fire)
      begin
        cause_watchdog <= 1'b1;
      end
      else if (write_edge && hit_cause && pwdata_in[wdog_pkg::CAUSE_WATCHDOG_BIT])
      begin
        cause_watchdog <= 1'b0;
      end
      if (internal_reset)
      begin
        break_disable <= 1'b0;
      end
      else if (write_edge && hit_break)
      begin
        break_disable <= pwdata_in[wdog_pkg::BREAK_DISABLE_BIT];
      end
    end
  end

  // Read mux
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    if (hit_clear)
    begin
      next_prdata[7:0] = wdog_pkg::RESET_VECTOR_LOW;
    end
    else if (hit_options)
    begin
      next_prdata[7:0] = options;
    end
    else if (hit_cause)
    begin
      next_prdata[wdog_pkg::CAUSE_WATCHDOG_BIT] = cause_watchdog;
    end
    else if (hit_break)
    begin
      next_prdata[wdog_pkg::BREAK_DISABLE_BIT] = break_disable;
    end
    else if (hit_status)
    begin
      next_prdata[CHAIN_W-1:0] = chain;
      next_prdata[29] = recovery_busy;
      next_prdata[30] = por_busy;
      next_prdata[31] = stopped_out;
    end
  end

  // No wait state: answer registered in the setup cycle
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      prdata_out <= 32'h0000_0000;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end
    else if (ce_in)
    begin
      pready_out <= setup_phase;
      if (setup_phase)
      begin
        prdata_out <= pwrite_in ? 32'h0000_0000 : next_prdata;
        pslverr_out <= !hit_any;
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic [7:0] oe_length;

  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in || !reset_pin_oe_out)
    begin
      oe_length <= 8'h00;
    end
    else if (ce_in)
    begin
      oe_length <= oe_length + 8'h01;
    end
  end

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);

  AST_PIN_LENGTH: assert property ($fell(reset_pin_oe_out) && $past(ce_in)
    |-> oe_length == 8'(wdog_pkg::PIN_PULSE_CYCLES)
    && $past(oe_length) == 8'(wdog_pkg::PIN_PULSE_CYCLES - 1)) else $error("reset pin pulse length wrong");
  AST_CAUSE_SET: assert property (fire && ce_in |=> cause_watchdog) else $error("cause flag not set");
  AST_CLEAR_PORT: assert property (write_edge && hit_clear && ce_in && !internal_reset
    && !stop_instr_in && !por_done |=> chain[CHAIN_W-1:4] == '0) else $error("clear port did not clear");
  AST_READ_VECTOR: assert property (setup_phase && !pwrite_in && hit_clear && ce_in
    |=> prdata_out == {24'h000000, wdog_pkg::RESET_VECTOR_LOW}) else $error("clear port read wrong");
  AST_DISABLED: assert property (options[wdog_pkg::OPT_DISABLE_BIT] |-> !fire) else $error("disabled fired");
  AST_MONITOR: assert property (monitor_mode_in && high_test_voltage_in |-> !fire) else $error("monitor fired");
  AST_STOP_HOLD: assert property (stop_state == wdog_pkg::ST_STOPPED && !internal_reset && !por_done
    |=> $stable(chain)) else $error("counted in stop");
  AST_SHORT_POINT: assert property (fire && options[wdog_pkg::OPT_PERIOD_SELECT_BIT]
    |-> chain[12:0] == 13'h1ff0) else $error("short timeout wrong");
  AST_LONG_POINT: assert property (fire && !options[wdog_pkg::OPT_PERIOD_SELECT_BIT]
    |-> chain[17:0] == 18'h3fff0) else $error("long timeout wrong");
  AST_ILLEGAL_STOP: assert property (stop_instr_in && ce_in && !options[wdog_pkg::OPT_STOP_ENABLE_BIT]
    && stop_state == wdog_pkg::ST_RUN && !internal_reset |=> illegal_opcode_out) else $error("stop not refused");
  AST_TRIP_KEEP: assert property (internal_reset |=> $stable(options[wdog_pkg::OPT_TRIP_SELECT_BIT]))
    else $error("trip select lost");
  AST_ONCE: assert property (options_locked && !internal_reset |=> $stable(options)) else $error("options rewritten");
  AST_SYS_RESET: assert property (fire && ce_in |=> system_reset_out ##1 !system_reset_out [*2])
    else $error("reset request shape wrong");

  COV_FIRE: cover property (fire);
  COV_PIN: cover property ($fell(reset_pin_oe_out));
  COV_RECOVER: cover property (stop_state == wdog_pkg::ST_RECOVER ##1 recovery_done);
  COV_CLEAR: cover property (write_edge && hit_clear);

endmodule : watchdog_with_config_options
`default_nettype wire

// ==== verification/tb_watchdog_with_config_options.sv ====
// Self-checking bench for the watchdog block: APB register access, timeouts, stop sequencing
// Assumes the design package is compiled first and the design answers APB with no wait state
`timescale 1ns/100ps
`default_nettype none
module tb_watchdog_with_config_options;
  localparam logic [17:0] A_CLR = {wdog_pkg::CLEAR_PORT_INDEX, 2'b00};
  localparam logic [17:0] A_OPT = {wdog_pkg::OPTIONS_INDEX, 2'b00};
  localparam logic [17:0] A_CAUSE = {wdog_pkg::CAUSE_INDEX, 2'b00};
  localparam logic [17:0] A_BRK = {wdog_pkg::BREAK_AUX_INDEX, 2'b00};
  logic sys_clk_in, reset_in, ce_in, psel_in, penable_in, pwrite_in, monitor_mode_in, high_test_voltage_in;
  logic break_active_in, stop_instr_in, wake_in, lvi_reset_in, internal_reset_in, err;
  logic [wdog_pkg::ADDR_W-1:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd;
  logic [3:0] pstrb_in;
  logic pready_out, pslverr_out, reset_pin_out, reset_pin_oe_out, system_reset_out, illegal_opcode_out;
  logic stopped_out, recovery_done_out, por_done_out, low_voltage_trip_select_out;
  int error_cnt, cmp_count, n;

  watchdog_with_config_options i_watchdog_with_config_options (.sys_clk_in, .reset_in, .ce_in, .psel_in,
    .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in, .prdata_out, .pready_out, .pslverr_out,
    .monitor_mode_in, .high_test_voltage_in, .break_active_in, .stop_instr_in, .wake_in, .lvi_reset_in,
    .internal_reset_in, .reset_pin_out, .reset_pin_oe_out, .system_reset_out, .illegal_opcode_out,
    .stopped_out, .recovery_done_out, .por_done_out, .low_voltage_trip_select_out);

  // ****************************************************************
  // Bus cycles and checks
  // ****************************************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    do
    begin
      @(posedge sys_clk_in);
    end
    while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb

  // Counts edges until the chosen output is seen high, or the limit
  task automatic wait_hi(input int sel, input int lim, output int c);
    logic s;
    c = 0;
    do
    begin
      @(posedge sys_clk_in);
      c++;
      case (sel)
        0: s = por_done_out;
        1: s = system_reset_out;
        2: s = recovery_done_out;
        default: s = illegal_opcode_out;
      endcase
    end
    while (s !== 1'b1 && c < lim);
  endtask : wait_hi

  task automatic stop_seq(input logic low_voltage_inhibit, output int c);
    @(posedge sys_clk_in);
    stop_instr_in <= 1'b1;
    @(posedge sys_clk_in);
    stop_instr_in <= 1'b0;
    @(posedge sys_clk_in);
    chk(stopped_out, 1);
    if (low_voltage_inhibit)
      lvi_reset_in <= 1'b1;
    else
      wake_in <= 1'b1;
    @(posedge sys_clk_in);
    lvi_reset_in <= 1'b0;
    wake_in <= 1'b0;
    wait_hi(2, 5000, c);
  endtask : stop_seq

  // Clears the watchdog, then times the next watchdog reset
  task automatic fire_time(input int lim, output int c);
    apb(1'b1, A_CLR, 32'h0000_00a5);
    wait_hi(1, lim, c);
  endtask : fire_time

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  // ****************************************************************
  // Clock, watchdog and test sequence
  // ****************************************************************
  initial
  begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end

  initial
  begin
    repeat (90000) @(posedge sys_clk_in);
    error_cnt++;
    stop_test;
  end

  initial
  begin
    {reset_in, ce_in, pstrb_in} = {1'b1, 1'b1, 4'hf};
    {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
    {monitor_mode_in, high_test_voltage_in, break_active_in} = '0;
    {stop_instr_in, wake_in, lvi_reset_in, internal_reset_in} = '0;
    error_cnt = 0;
    cmp_count = 0;
    repeat (3) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    wait_hi(0, 5000, n);
    chk(n >= 4094 && n <= 4099, 1);
    apb(1'b0, A_OPT, '0);
    chk(rd, 32'h0000_0000);
    apb(1'b0, A_CLR, '0);
    chk(rd, {24'h0, wdog_pkg::RESET_VECTOR_LOW});
    apb(1'b0, 18'h00100, '0);
    chk(err, 1);
    apb(1'b1, A_OPT, 32'h0000_009e);
    apb(1'b1, A_OPT, 32'h0000_0000);
    apb(1'b0, A_OPT, '0);
    chk(rd, 32'h0000_009e);
    chk(low_voltage_trip_select_out, 1);
    stop_seq(1'b0, n);
    chk(n >= 29 && n <= 36, 1);
    chk(stopped_out, 0);
    fire_time(4000, n);
    chk(n, 4000);
    fire_time(9000, n);
    chk(n >= 8158 && n <= 8180, 1);
    n = 0;
    while (reset_pin_oe_out === 1'b1 && n < 100)
    begin
      n++;
      chk(reset_pin_out, 0);
      @(posedge sys_clk_in);
    end
    chk(n, 32);
    apb(1'b0, A_CAUSE, '0);
    chk(rd, 32'h0000_0001);
    apb(1'b0, A_OPT, '0);
    chk(rd, 32'h0000_0018);
    chk(low_voltage_trip_select_out, 1);
    @(posedge sys_clk_in);
    stop_instr_in <= 1'b1;
    @(posedge sys_clk_in);
    stop_instr_in <= 1'b0;
    wait_hi(3, 3, n);
    chk(illegal_opcode_out, 1);
    apb(1'b1, A_CAUSE, 32'h0000_0001);
    apb(1'b0, A_CAUSE, '0);
    chk(rd, 32'h0000_0000);
    apb(1'b1, A_OPT, 32'h0000_0099);
    fire_time(9000, n);
    chk(n, 9000);
    @(posedge sys_clk_in);
    internal_reset_in <= 1'b1;
    @(posedge sys_clk_in);
    internal_reset_in <= 1'b0;
    apb(1'b0, A_OPT, '0);
    chk(rd, 32'h0000_0018);
    pstrb_in <= 4'he;
    apb(1'b1, A_OPT, 32'h0000_0099);
    pstrb_in <= 4'hf;
    apb(1'b0, A_OPT, '0);
    chk(rd, 32'h0000_0018);
    apb(1'b1, A_OPT, 32'h0000_0098);
    monitor_mode_in <= 1'b1;
    high_test_voltage_in <= 1'b1;
    fire_time(9000, n);
    chk(n, 9000);
    high_test_voltage_in <= 1'b0;
    break_active_in <= 1'b1;
    apb(1'b1, A_BRK, 32'h0000_0001);
    fire_time(9000, n);
    chk(n, 9000);
    monitor_mode_in <= 1'b0;
    break_active_in <= 1'b0;
    fire_time(9000, n);
    chk(n >= 8158 && n <= 8180, 1);
    apb(1'b1, A_OPT, 32'h0000_001e);
    stop_seq(1'b1, n);
    chk(n >= 4093 && n <= 4100, 1);
    stop_test;
  end
endmodule : tb_watchdog_with_config_options
`default_nettype wire
